// file: hdl/scd_top.sv
// Scan and clock diagnostic controller: burst, shifter, request port
//
// Notes on behaviour
// [R1] Burst emits 1 to 255 clocks, then stops
// [R2] Read recirculates string, captures eight bits
// [R3] Each byte moved uses one eight-clock burst
// [R4] Edit held bits, then shift string back
// [R5] One sync line per board, subset clocked
// [R6] Boards clock themselves only from sync line
// [R7] 28 return inputs, one selected by mux
// [R8] Processor sets command, then pulses request
// [R9] Request latches command, interrupts controller
// [R10] Drive 16-bit word, then pulse response
// [R11] Power, character, stop, request, tick interrupt; tick only raised when VARIANT_B is set
// [R12] Shutdown arrives on non-maskable interrupt
// [R13] Maskable line carries watchdog on one variant
// [R14] 56K read-only, 8K read/write decode
// [R15] Lowest read/write kilobyte is battery-backed
// [R16] Functions reached through processor I/O ports
// [R17] One-hour elapsed counter keeps running
// [R18] Force signals, pattern test, report failing address
// [R19] Inject one microword, compare result
// [R20] Local differential and remote console ports
// [R21] Strobes at least one system clock wide
// [R22] Shift bits least significant first
module scd_top #(
    parameter bit VARIANT_B = 1'b0
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire scd_pkg::scd_bus_s cpu_bus,
    output logic      [7:0]        cpu_rdata,
    output logic                   rom_cs,
    output logic                   ram_cs,
    output logic                   batt_ram_cs,
    output logic                   int_n,
    output logic                   nmi_n,
    output logic                   event_irq,
    input  wire logic              shutdown_req,
    input  wire logic              watchdog_irq,
    input  wire logic              ac_fault,
    input  wire logic              dc_fault,
    input  wire logic              char_rx,
    input  wire logic              sys_stop,
    input  wire logic              sec_tick,
    input  wire logic              sys_clk_in,
    output logic      [27:0]       board_sync,
    input  wire logic [27:0]       board_ret,
    output logic                   board_shift_in,
    output logic      [7:0]        force_ctrl,
    input  wire logic [2:0]        cpu_cmd,
    input  wire logic              cpu_request_strobe,
    output logic      [15:0]       resp_data,
    output logic                   response_ready_strobe,
    output logic                   local_txd,
    output logic                   remote_txd,
    input  wire logic              local_rxd,
    input  wire logic              remote_rxd
);

    // ----------
    // Input synchronisers
    // ----------
    localparam int SW = scd_pkg::NUM_BOARDS + scd_pkg::CMD_W + 11;

    logic [SW-1:0]     async_in;
    logic [SW-1:0]     sync_in;
    logic [27:0]       ret_s;
    logic [2:0]        cmd_s;
    logic              sclk_s;
    logic              req_s;
    logic              shut_s;
    logic              wdog_s;
    logic              lrx_s;
    logic              rrx_s;
    logic [4:0]        ev_lvl;
    scd_pkg::scd_evt_s evt_s;

    assign async_in = {board_ret, cpu_cmd, sys_clk_in, cpu_request_strobe,
                       shutdown_req, watchdog_irq, local_rxd, remote_rxd,
                       ac_fault, dc_fault, char_rx, sys_stop, sec_tick};

    scd_sync2 #(.W(SW)) u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .d       (async_in),
        .q       (sync_in)
    );

    assign {ret_s, cmd_s, sclk_s, req_s, shut_s, wdog_s, lrx_s, rrx_s,
            ev_lvl} = sync_in;

    // ------------------------------------------------------------
    // Edge detection on synchronised levels
    // ------------------------------------------------------------
    logic       sclk_d_r;
    logic       req_d_r;
    logic       tick_d_r;
    logic       sclk_rise;
    logic       req_rise;
    logic       tick_rise;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sclk_d_r <= 1'b0;
            req_d_r  <= 1'b0;
            tick_d_r <= 1'b0;
        end
        else
        begin
            sclk_d_r <= sclk_s;
            req_d_r  <= req_s;
            tick_d_r <= evt_s.sec_tick;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign req_rise  = req_s & ~req_d_r;
    assign tick_rise = evt_s.sec_tick & ~tick_d_r;
    assign evt_s     = {ev_lvl[4:1], req_rise, ev_lvl[0]};

    // ----------
    // Memory decode
    // ----------
    always_comb
    begin
        rom_cs      = cpu_bus.mreq & (cpu_bus.addr <= scd_pkg::ROM_TOP);  // [R14]
        ram_cs      = cpu_bus.mreq & (cpu_bus.addr >= scd_pkg::RAM_BASE); // [R14]
        batt_ram_cs = ram_cs & (cpu_bus.addr <= scd_pkg::BATT_TOP);       // [R15]
    end

    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_a;

    assign io_wr = cpu_bus.iorq & cpu_bus.wr; // [R16]
    assign io_rd = cpu_bus.iorq & cpu_bus.rd; // [R16]
    assign io_a  = cpu_bus.addr[7:0];

    // ------------------------------------------------------------
    // Burst generator and shifter
    // ------------------------------------------------------------
    scd_pkg::scd_burst_e            bst_r, bst_nxt;
    logic [7:0]                     remain_r, remain_nxt;
    logic [7:0]                     shreg_r, shreg_nxt;
    logic                           wb_r, wb_nxt;
    logic                           sync_on_r, sync_on_nxt;
    logic                           shin_r, shin_nxt;
    logic [27:0]                    mask_r, mask_nxt;
    logic [4:0]                     board_r, board_nxt;
    logic                           ret_bit;

    assign ret_bit = (board_r < 5'(scd_pkg::NUM_BOARDS)) ?
                     ret_s[board_r] : 1'b0; // [R7]

    always_comb
    begin
        bst_nxt     = bst_r;
        remain_nxt  = remain_r;
        shreg_nxt   = shreg_r;
        wb_nxt      = wb_r;
        sync_on_nxt = sync_on_r;
        shin_nxt    = wb_r ? shreg_r[0] : ret_bit; // [R2] [R4]
        mask_nxt    = mask_r;
        board_nxt   = board_r;
        if (io_wr && bst_r == scd_pkg::BST_IDLE)
        begin
            unique case (io_a)
                scd_pkg::P_SYNC0: mask_nxt[7:0]   = cpu_bus.wdata; // [R5]
                scd_pkg::P_SYNC1: mask_nxt[15:8]  = cpu_bus.wdata;
                scd_pkg::P_SYNC2: mask_nxt[23:16] = cpu_bus.wdata;
                scd_pkg::P_SYNC3: mask_nxt[27:24] = cpu_bus.wdata[3:0];
                scd_pkg::P_BOARD: board_nxt       = cpu_bus.wdata[4:0];
                scd_pkg::P_BURST:
                begin
                    remain_nxt = cpu_bus.wdata; // [R1]
                    wb_nxt     = 1'b0;
                    if (cpu_bus.wdata != 8'h00)
                        bst_nxt = scd_pkg::BST_ARM;
                end
                scd_pkg::P_SHWRITE:
                begin
                    shreg_nxt  = cpu_bus.wdata; // [R4]
                    remain_nxt = 8'(scd_pkg::BYTE_BITS); // [R3]
                    wb_nxt     = 1'b1;
                    bst_nxt    = scd_pkg::BST_ARM;
                end
                scd_pkg::P_SHREAD:
                begin
                    remain_nxt = 8'(scd_pkg::BYTE_BITS); // [R3]
                    wb_nxt     = 1'b0;
                    bst_nxt    = scd_pkg::BST_ARM;
                end
                default: ;
            endcase
        end
        unique case (bst_r)
            scd_pkg::BST_IDLE: ;
            scd_pkg::BST_ARM:
            begin
                if (sclk_rise)
                begin
                    sync_on_nxt = 1'b1; // [R5] [R6]
                    bst_nxt     = scd_pkg::BST_RUN;
                end
            end
            scd_pkg::BST_RUN:
            begin
                if (sclk_rise)
                begin
                    shreg_nxt  = {ret_bit, shreg_r[7:1]}; // [R22]
                    remain_nxt = remain_r - 8'h01;
                    if (remain_r == 8'h01)
                    begin
                        sync_on_nxt = 1'b0; // [R1]
                        bst_nxt     = scd_pkg::BST_IDLE;
                    end
                end
            end
            default: bst_nxt = scd_pkg::BST_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            bst_r     <= scd_pkg::BST_IDLE;
            remain_r  <= 8'h00;
            shreg_r   <= 8'h00;
            wb_r      <= 1'b0;
            sync_on_r <= 1'b0;
            shin_r    <= 1'b0;
            mask_r    <= scd_pkg::SYNC_MASK_RST;
            board_r   <= 5'h00;
        end
        else
        begin
            bst_r     <= bst_nxt;
            remain_r  <= remain_nxt;
            shreg_r   <= shreg_nxt;
            wb_r      <= wb_nxt;
            sync_on_r <= sync_on_nxt;
            shin_r    <= shin_nxt;
            mask_r    <= mask_nxt;
            board_r   <= board_nxt;
        end
    end

    assign board_sync     = sync_on_r ? mask_r : '0; // [R5]
    assign board_shift_in = shin_r;

    // ------------------------------------------------------------
    // Processor request and response port
    // ------------------------------------------------------------
    logic [2:0]  cmd_r, cmd_nxt;
    logic [15:0] resp_r, resp_nxt;
    logic [15:0] rstage_r, rstage_nxt;
    logic [4:0]  rcnt_r, rcnt_nxt;

    always_comb
    begin
        cmd_nxt    = cmd_r;
        resp_nxt   = resp_r;
        rstage_nxt = rstage_r;
        rcnt_nxt   = rcnt_r;
        if (req_rise)
            cmd_nxt = cmd_s; // [R8] [R9]
        if (rcnt_r != 5'h00)
            rcnt_nxt = rcnt_r - 5'h01;
        if (io_wr && io_a == scd_pkg::P_RESP_LO)
            rstage_nxt[7:0] = cpu_bus.wdata;
        if (io_wr && io_a == scd_pkg::P_RESP_HI)
            rstage_nxt[15:8] = cpu_bus.wdata;
        if (io_wr && io_a == scd_pkg::P_RESP_GO && rcnt_r == 5'h00)
        begin
            resp_nxt = rstage_r; // [R10]
            rcnt_nxt = 5'(scd_pkg::RESP_PULSE_CYC) + 5'h01; // [R21]
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            cmd_r    <= 3'h0;
            resp_r   <= 16'h0000;
            rstage_r <= 16'h0000;
            rcnt_r   <= 5'h00;
        end
        else
        begin
            cmd_r    <= cmd_nxt;
            resp_r   <= resp_nxt;
            rstage_r <= rstage_nxt;
            rcnt_r   <= rcnt_nxt;
        end
    end

    assign resp_data = resp_r;
    // Data settles one cycle before the strobe rises
    assign response_ready_strobe = (rcnt_r != 5'h00) &&
        (rcnt_r <= 5'(scd_pkg::RESP_PULSE_CYC)); // [R10] [R21]

    // ------------------------------------------------------------
    // Events, interrupt lines, elapsed time, test and console
    // ------------------------------------------------------------
    logic [5:0]  pend_r, pend_nxt;
    logic [11:0] etc_r, etc_nxt;
    logic [7:0]  force_r, force_nxt;
    logic [7:0]  expect_r, expect_nxt;
    logic [15:0] taddr_r, taddr_nxt;
    logic [15:0] fail_r, fail_nxt;
    logic        fflag_r, fflag_nxt;
    logic [1:0]  txd_r, txd_nxt;
    logic [5:0]  evt_now;

    always_comb
    begin
        evt_now    = evt_s;
        if (!VARIANT_B)
            evt_now[0] = 1'b0; // [R11]
        else
            evt_now[0] = tick_rise; // [R11]
        pend_nxt   = pend_r;
        etc_nxt    = etc_r;
        force_nxt  = force_r;
        expect_nxt = expect_r;
        taddr_nxt  = taddr_r;
        fail_nxt   = fail_r;
        fflag_nxt  = fflag_r;
        txd_nxt    = txd_r;
        if (io_wr && io_a == scd_pkg::P_EVENT)
            pend_nxt = pend_r & ~cpu_bus.wdata[5:0];
        pend_nxt = pend_nxt | evt_now; // [R11] [R9]
        if (tick_rise)
            etc_nxt = (etc_r == 12'(scd_pkg::ETC_RANGE_S - 1)) ?
                      12'h000 : etc_r + 12'h001; // [R17]
        if (io_wr)
        begin
            unique case (io_a)
                scd_pkg::P_FORCE:    force_nxt  = cpu_bus.wdata; // [R18]
                scd_pkg::P_EXPECT:   expect_nxt = cpu_bus.wdata; // [R19]
                scd_pkg::P_TADDR_LO: taddr_nxt[7:0]  = cpu_bus.wdata;
                scd_pkg::P_TADDR_HI: taddr_nxt[15:8] = cpu_bus.wdata;
                scd_pkg::P_SERIAL:   txd_nxt = cpu_bus.wdata[1:0]; // [R20]
                scd_pkg::P_COMPARE:
                begin
                    fflag_nxt = shreg_r != expect_r; // [R19]
                    if (shreg_r != expect_r)
                        fail_nxt = taddr_r; // [R18]
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pend_r   <= 6'h00;
            etc_r    <= 12'h000;
            force_r  <= scd_pkg::FORCE_RST;
            expect_r <= 8'h00;
            taddr_r  <= 16'h0000;
            fail_r   <= 16'h0000;
            fflag_r  <= 1'b0;
            txd_r    <= scd_pkg::TXD_RST;
        end
        else
        begin
            pend_r   <= pend_nxt;
            etc_r    <= etc_nxt;
            force_r  <= force_nxt;
            expect_r <= expect_nxt;
            taddr_r  <= taddr_nxt;
            fail_r   <= fail_nxt;
            fflag_r  <= fflag_nxt;
            txd_r    <= txd_nxt;
        end
    end

    assign event_irq  = |pend_r; // [R11]
    assign nmi_n      = ~shut_s; // [R12]
    assign int_n      = VARIANT_B ? ~wdog_s : 1'b1; // [R13]
    assign force_ctrl = force_r;
    assign local_txd  = txd_r[0];
    assign remote_txd = txd_r[1];

    // ----------
    // Port read data
    // ----------
    logic [7:0] rd_r, rd_nxt;

    always_comb
    begin
        rd_nxt = rd_r;
        if (io_rd)
        begin
            unique case (io_a)
                scd_pkg::P_SYNC0:   rd_nxt = mask_r[7:0];
                scd_pkg::P_SYNC1:   rd_nxt = mask_r[15:8];
                scd_pkg::P_SYNC2:   rd_nxt = mask_r[23:16];
                scd_pkg::P_SYNC3:   rd_nxt = {4'h0, mask_r[27:24]};
                scd_pkg::P_BOARD:   rd_nxt = {3'h0, board_r};
                scd_pkg::P_SHREAD:  rd_nxt = shreg_r; // [R2]
                scd_pkg::P_STATUS:  rd_nxt = {4'h0, fflag_r,
                                     rcnt_r != 5'h00, event_irq,
                                     bst_r != scd_pkg::BST_IDLE};
                scd_pkg::P_REQCMD:  rd_nxt = {5'h00, cmd_r}; // [R9]
                scd_pkg::P_EVENT:   rd_nxt = {2'h0, pend_r};
                scd_pkg::P_ETC_LO:  rd_nxt = etc_r[7:0];
                scd_pkg::P_ETC_HI:  rd_nxt = {4'h0, etc_r[11:8]};
                scd_pkg::P_FORCE:   rd_nxt = force_r;
                scd_pkg::P_FAIL_LO: rd_nxt = fail_r[7:0];
                scd_pkg::P_FAIL_HI: rd_nxt = fail_r[15:8];
                scd_pkg::P_SERIAL:  rd_nxt = {6'h00, rrx_s, lrx_s};
                default:            rd_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            rd_r <= 8'h00;
        else
            rd_r <= rd_nxt;
    end

    assign cpu_rdata = rd_r;

endmodule

// file: hdl/scd_pkg.sv
// Shared constants and types for the scan and clock diagnostic controller
package scd_pkg;

    // ----------
    // Timing
    // ----------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int RESP_PULSE_NS  = 800;
    localparam int RESP_PULSE_CYC =
        (RESP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ETC_RANGE_S    = 3600;

    // ----------
    // Sizes
    // ----------
    localparam int NUM_BOARDS = 28;
    localparam int BYTE_BITS  = 8;
    localparam int CMD_W      = 3;
    localparam int RESP_W     = 16;

    // ----------
    // Control processor memory map
    // ----------
    localparam logic [15:0] ROM_TOP   = 16'hdfff;
    localparam logic [15:0] RAM_BASE  = 16'he000;
    localparam logic [15:0] BATT_TOP  = 16'he3ff;

    // ----------
    // Control processor I/O ports
    // ----------
    localparam logic [7:0] P_SYNC0    = 8'h00;
    localparam logic [7:0] P_SYNC1    = 8'h01;
    localparam logic [7:0] P_SYNC2    = 8'h02;
    localparam logic [7:0] P_SYNC3    = 8'h03;
    localparam logic [7:0] P_BURST    = 8'h04;
    localparam logic [7:0] P_BOARD    = 8'h05;
    localparam logic [7:0] P_SHWRITE  = 8'h06;
    localparam logic [7:0] P_SHREAD   = 8'h07;
    localparam logic [7:0] P_STATUS   = 8'h08;
    localparam logic [7:0] P_REQCMD   = 8'h09;
    localparam logic [7:0] P_EVENT    = 8'h0a;
    localparam logic [7:0] P_RESP_LO  = 8'h0b;
    localparam logic [7:0] P_RESP_HI  = 8'h0c;
    localparam logic [7:0] P_RESP_GO  = 8'h0d;
    localparam logic [7:0] P_ETC_LO   = 8'h0e;
    localparam logic [7:0] P_ETC_HI   = 8'h0f;
    localparam logic [7:0] P_FORCE    = 8'h10;
    localparam logic [7:0] P_EXPECT   = 8'h11;
    localparam logic [7:0] P_TADDR_LO = 8'h12;
    localparam logic [7:0] P_TADDR_HI = 8'h13;
    localparam logic [7:0] P_COMPARE  = 8'h14;
    localparam logic [7:0] P_FAIL_LO  = 8'h15;
    localparam logic [7:0] P_FAIL_HI  = 8'h16;
    localparam logic [7:0] P_SERIAL   = 8'h17;

    // ----------
    // Reset values
    // ----------
    localparam logic [27:0] SYNC_MASK_RST = 28'h0000000;
    localparam logic [7:0]  FORCE_RST     = 8'h00;
    localparam logic [1:0]  TXD_RST       = 2'h3;

    // ----------
    // Types
    // ----------
    typedef struct packed {
        logic ac_fault;
        logic dc_fault;
        logic char_rx;
        logic sys_stop;
        logic cpu_req;
        logic sec_tick;
    } scd_evt_s;

    typedef struct packed {
        logic                 mreq;
        logic                 iorq;
        logic                 rd;
        logic                 wr;
        logic [15:0]          addr;
        logic [7:0]           wdata;
    } scd_bus_s;

    typedef enum logic [2:0] {
        BST_IDLE = 3'b001,
        BST_ARM  = 3'b010,
        BST_RUN  = 3'b100
    } scd_burst_e;

endpackage

// file: hdl/scd_sync2.sv
// Two-stage synchroniser for inputs from outside the clock domain
module scd_sync2 #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

// file: testbench/scd_top_asserts.sv
// Port checks for the diagnostic controller
module scd_top_asserts (
    input wire logic              mclk,
    input wire logic              sys_rst,
    input wire scd_pkg::scd_bus_s cpu_bus,
    input wire logic              rom_cs,
    input wire logic              ram_cs,
    input wire logic              batt_ram_cs,
    input wire logic              nmi_n,
    input wire logic              event_irq,
    input wire logic              shutdown_req,
    input wire logic [27:0]       board_sync,
    input wire logic              cpu_request_strobe,
    input wire logic              response_ready_strobe
);
    logic [31:0] mask_r;
    logic [7:0]  num_r;
    logic [11:0] on_r;
    logic [4:0]  hi_r;
    wire logic       wr_io = cpu_bus.iorq && cpu_bus.wr && board_sync == '0;
    wire logic [7:0] io_a  = cpu_bus.addr[7:0];
    wire logic [11:0] len8 = {1'b0, num_r, 3'h0};

    // ----
    // Track mask, burst length and pulse widths
    // ----
    always_ff @(posedge mclk)
    begin
        if (wr_io && io_a < 8'h04)
            mask_r[io_a[1:0] * 8 +: 8] <= cpu_bus.wdata;
        if (wr_io && io_a == 8'h04)
            num_r <= cpu_bus.wdata;
        if (wr_io && io_a[7:1] == 7'h03)
            num_r <= 8'h08;
        on_r <= (board_sync != '0) ? on_r + 12'h1 : 12'h0;
        hi_r <= response_ready_strobe ? hi_r + 5'h1 : 5'h0;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_go; wr_io && io_a == 8'h0d && !response_ready_strobe;
    endsequence
    sequence s_pulse; !response_ready_strobe ##1 response_ready_strobe;
    endsequence
    property p_go; s_go |=> s_pulse;
    endproperty
    a_go: assert property (p_go) else $error("response late");
    property p_width; $fell(response_ready_strobe) |-> hi_r == 5'h10;
    endproperty
    a_width: assert property (p_width) else $error("pulse width");
    property p_burst; $fell(|board_sync) |->
        on_r + 12'h2 >= len8 && on_r <= len8 + 12'h2;
    endproperty
    a_burst: assert property (p_burst) else $error("burst length");
    property p_mask; board_sync != '0 |-> board_sync == mask_r[27:0];
    endproperty
    a_mask: assert property (p_mask) else $error("sync subset");
    property p_rom; cpu_bus.mreq |->
        rom_cs == (cpu_bus.addr <= 16'hdfff) && ram_cs != rom_cs;
    endproperty
    a_rom: assert property (p_rom) else $error("memory decode");
    property p_batt; batt_ram_cs == (ram_cs && cpu_bus.addr <= 16'he3ff);
    endproperty
    a_batt: assert property (p_batt) else $error("backed decode");
    property p_nmi; $stable(shutdown_req)[*6] |-> nmi_n != shutdown_req;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi level");
    property p_req; $rose(cpu_request_strobe) |-> ##[2:6] event_irq;
    endproperty
    a_req: assert property (p_req) else $error("request irq");
endmodule

bind scd_top scd_top_asserts scd_top_asserts_i (.*);

// file: testbench/scd_board_model.sv
// Processor boards: shift strings, sync-gated clocks, request port
module scd_board_model (
    input  wire logic        mclk,
    input  wire logic        sys_clk,
    input  wire logic [27:0] board_sync,
    input  wire logic        board_shift_in,
    output logic      [27:0] board_ret,
    output logic      [2:0]  cpu_cmd,
    output logic             cpu_request_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] chain [28];
    int          clocks [28];
    initial
    begin
        cpu_cmd = 3'h0;
        cpu_request_strobe = 1'b0;
        board_ret = 28'h0;
        foreach (chain[i])
            chain[i] = 16'(i * 16'h1357);
    end
    // Boards step only on clocks let through by their sync
    always @(posedge sys_clk)
        foreach (chain[i])
            if (board_sync[i])
            begin
                chain[i] <= {board_shift_in, chain[i][15:1]};
                clocks[i] <= clocks[i] + 1;
            end
    // Output settles half a period after the clock
    always @(negedge sys_clk)
        foreach (chain[i])
            board_ret[i] <= chain[i][0];
    task automatic request(input logic [2:0] cmd);
        cpu_cmd <= cmd;
        repeat (2) @(posedge mclk);
        cpu_request_strobe <= 1'b1;
        repeat (10) @(posedge mclk);
        cpu_request_strobe <= 1'b0;
        @(posedge mclk);
    endtask
endmodule

// file: testbench/scd_top_tb.sv
// Self-checking bench for the diagnostic controller
module scd_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic              mclk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              sys_clk_in = 1'b0;
    logic              shutdown_req = 1'b0;
    logic [3:0]        evt = 4'h0;
    scd_pkg::scd_bus_s cpu_bus = '0;
    logic [7:0]        rd, b;
    logic              rom_cs, ram_cs, batt, nmi_n, int_n, irq, shin, strb;
    logic [27:0]       sync, ret;
    logic [2:0]        cmd;
    logic              req;
    logic [15:0]       resp, adr [6];
    logic [7:0]        cnt [4];
    logic [15:0]       exp_q [$];
    int                error_cnt = 0;
    int                check_count = 0;
    int                k;

    scd_top scd_top_i (.mclk, .sys_rst, .cpu_bus, .cpu_rdata(rd), .rom_cs,
        .ram_cs, .batt_ram_cs(batt), .int_n, .nmi_n, .event_irq(irq),
        .shutdown_req, .watchdog_irq(1'b0), .ac_fault(evt[3]),
        .dc_fault(evt[2]), .char_rx(evt[1]), .sys_stop(evt[0]),
        .sec_tick(1'b0), .sys_clk_in, .board_sync(sync), .board_ret(ret),
        .board_shift_in(shin), .force_ctrl(), .cpu_cmd(cmd),
        .cpu_request_strobe(req), .resp_data(resp),
        .response_ready_strobe(strb), .local_txd(), .remote_txd(),
        .local_rxd(1'b1), .remote_rxd(1'b1));
    scd_board_model scd_board_model_i (.mclk, .sys_clk(sys_clk_in),
        .board_sync(sync), .board_shift_in(shin), .board_ret(ret),
        .cpu_cmd(cmd), .cpu_request_strobe(req));

    always #25 mclk = ~mclk;
    initial
    begin
        #37;
        forever #200 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge strb) chk(resp, exp_q.pop_front());

    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic io(input logic w, input logic [7:0] a, d);
        cpu_bus <= {2'b01, !w, w, 8'h00, a, d};
        @(posedge mclk);
        cpu_bus <= '0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic idle;
        int i;
        i = 0;
        do
        begin
            io(1'b0, 8'h08, 8'h00);
            i++;
        end
        while (rd[0] !== 1'b0 && i < 1000);
        if (i >= 1000)
            error_cnt++;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #2000000;
        error_cnt++;
        tally_and_finish;
    end

    initial
    begin
        void'($urandom(23));
        adr = '{16'h0000, 16'hdfff, 16'he000, 16'he3ff, 16'he400, 16'hffff};
        cnt = '{8'h01, 8'hff, 8'h00, 8'($urandom_range(254, 2))};
        k = $urandom_range(27);
        b = $urandom;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({sync, strb, nmi_n}, {28'h0, 2'b01});
        foreach (adr[i])
        begin
            cpu_bus <= {4'b1010, adr[i], 8'h00};
            @(negedge mclk);
            chk({rom_cs, ram_cs, batt}, {adr[i] <= 16'hdfff,
                adr[i] >= 16'he000, adr[i][15:10] == 6'h38});
            @(posedge mclk);
        end
        $display("test decode done");
        io(1'b1, 8'h05, 8'(k));
        for (int i = 0; i < 4; i++)
            io(1'b1, 8'(i), 8'((32'h1 << k) >> (8 * i)));
        io(1'b1, 8'h06, b);
        idle;
        chk(scd_board_model_i.clocks[k], 8);
        chk(scd_board_model_i.chain[k][15:8], b);
        chk(scd_board_model_i.clocks[(k + 1) % 28], 0);
        scd_board_model_i.chain[k] = 16'($urandom);
        b = scd_board_model_i.chain[k][7:0];
        repeat (12) @(posedge mclk);
        io(1'b1, 8'h07, 8'h00);
        idle;
        io(1'b0, 8'h07, 8'h00);
        chk(rd, b);
        $display("test shift done");
        foreach (cnt[i])
        begin
            scd_board_model_i.clocks[k] = 0;
            io(1'b1, 8'h04, cnt[i]);
            idle;
            chk(scd_board_model_i.clocks[k], cnt[i]);
        end
        $display("test burst done");
        for (int c = 0; c < 8; c++)
        begin
            scd_board_model_i.request(3'(c));
            io(1'b0, 8'h09, 8'h00);
            chk({irq, rd[2:0]}, {1'b1, 3'(c)});
            io(1'b1, 8'h0a, 8'hff);
            b = $urandom;
            io(1'b1, 8'h0b, b);
            io(1'b1, 8'h0c, ~b ^ 8'(c));
            exp_q.push_back({~b ^ 8'(c), b});
            io(1'b1, 8'h0d, 8'h00);
            repeat (20) @(posedge mclk);
        end
        chk(exp_q.size(), 0);
        $display("test request done");
        for (int e = 0; e < 4; e++)
        begin
            evt <= 4'(1 << e);
            repeat (6) @(posedge mclk);
            evt <= 4'h0;
            repeat (4) @(posedge mclk);
            chk(irq, 1);
            io(1'b1, 8'h0a, 8'hff);
            chk(irq, 0);
        end
        $display("test events done");
        shutdown_req <= 1'b1;
        repeat (6) @(posedge mclk);
        chk({nmi_n, int_n}, 2'b01);
        shutdown_req <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(nmi_n, 1);
        $display("test nmi done");
        tally_and_finish;
    end
endmodule
